// ### design/lbf_bridge.sv
// learning bridge forwarding engine with aging and permanent filter tables
`timescale 1ns/10ps
`default_nettype none
`include "lbf_consts.svh"
module lbf_bridge (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // settings, counts of clock cycles
  input wire logic [31:0] learnInterval,
  input wire logic [31:0] ageInterval,
  // received frame header
  input wire logic frmValid,
  output logic frmReady,
  input wire logic [47:0] frmSrc,
  input wire logic [47:0] frmDst,
  input wire logic frmPort,
  // forwarding decision
  output logic decValid_ff,
  output logic decForward_ff,
  output logic decPort_ff,
  // permanent table management
  input wire logic permWrEn,
  input wire logic [`LBF_PERM_IW-1:0] permIdx,
  input wire logic permValidIn,
  input wire logic [47:0] permMacIn,
  input wire logic permPortIn,
  // status
  output logic learning_ff,
  output logic [11:0] count_ff,
  output logic fullAlarm_ff
);
  // ****************************************
  // state and storage
  // ****************************************
  lbf_pkg::lbf_state_t state_ff, nxt_state;
  logic dstPhase_ff;
  logic [47:0] srcMac_ff, dstMac_ff;
  logic arrPort_ff;
  logic [`LBF_ADDR_W-1:0] scanIdx_ff, rdIdx_ff, hitIdx_ff, freeIdx_ff;
  logic issuing_ff, rdValid_ff, hit_ff, freeFound_ff;
  lbf_pkg::lbf_entry_t hitEnt_ff, rdEnt, wrEnt;
  logic [`LBF_ENTRY_W-1:0] rdData;
  logic [31:0] learnCnt_ff, ageCnt_ff;
  logic ageDue_ff, armed_ff;
  logic [`LBF_PERM_N-1:0] permValid_ff, permPort_ff;
  logic [`LBF_PERM_N-1:0] [47:0] permMac_ff;

  // ****************************************
  // helpers
  // ****************************************
  // build an entry: address, port, location flag, freshness
  function automatic lbf_pkg::lbf_entry_t mkEntry(input logic [47:0] mac, input logic port,
                                                  input logic unk, input logic fresh);
    lbf_pkg::lbf_entry_t e;
    e.valid = 1'b1;
    e.fresh = fresh;
    e.unknownLoc = unk;
    e.port = port;
    e.mac = mac;
    return e;
  endfunction : mkEntry

  // search the permanent table: {hit, port}
  function automatic logic [1:0] permFind(input logic [47:0] mac, input logic [`LBF_PERM_N-1:0] vld,
                                          input logic [`LBF_PERM_N-1:0] prt,
                                          input logic [`LBF_PERM_N-1:0] [47:0] macs);
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < `LBF_PERM_N; i++) begin
      if (vld[i] && macs[i] == mac) begin
        r = {1'b1, prt[i]};
      end
    end
    return r;
  endfunction : permFind

  // ****************************************
  // decode
  // ****************************************
  wire logic isInit = state_ff == lbf_pkg::ST_INIT;
  wire logic isScan = state_ff == lbf_pkg::ST_SCAN;
  wire logic isUpd = state_ff == lbf_pkg::ST_UPDATE;
  wire logic isAge = state_ff == lbf_pkg::ST_AGE;
  wire logic lastIssue = issuing_ff && scanIdx_ff == `LBF_LAST_IDX;
  wire logic scanDone = rdValid_ff && rdIdx_ff == `LBF_LAST_IDX;
  wire logic tableFull = count_ff == `LBF_FULL_CNT;
  wire logic [47:0] key = dstPhase_ff ? dstMac_ff : srcMac_ff;
  wire logic [1:0] permSrc = permFind(srcMac_ff, permValid_ff, permPort_ff, permMac_ff);
  wire logic [1:0] permDst = permFind(dstMac_ff, permValid_ff, permPort_ff, permMac_ff);
  wire logic permHit = dstPhase_ff ? permDst[1] : permSrc[1];
  wire logic scanHit = rdValid_ff && rdEnt.valid && rdEnt.mac == key;
  wire logic scanFree = rdValid_ff && !rdEnt.valid;
  assign rdEnt = rdData;
  // table writes: clearing, aging, learning
  wire logic ageWr = isAge && rdValid_ff && rdEnt.valid;
  wire logic purge = ageWr && !rdEnt.fresh;
  wire logic updWr = isUpd && !permHit && (hit_ff || !tableFull);
  wire logic insertNow = updWr && !hit_ff;
  wire logic wrEn = isInit || ageWr || updWr;
  wire logic [`LBF_ADDR_W-1:0] wrIdx = isInit ? scanIdx_ff : isAge ? rdIdx_ff :
                                       hit_ff ? hitIdx_ff : freeIdx_ff;
  wire logic learnTick = learnCnt_ff >= learnInterval;
  wire logic ageTick = ageCnt_ff >= ageInterval;
  // write data per source of the write
  always_comb begin
    wrEnt = '0;
    if (isAge) begin
      if (!purge) begin
        wrEnt = mkEntry(rdEnt.mac, rdEnt.port, rdEnt.unknownLoc, 1'b0);
      end
    end else if (isUpd && !dstPhase_ff) begin
      wrEnt = mkEntry(srcMac_ff, arrPort_ff, 1'b0, 1'b1);
    end else if (isUpd && hit_ff) begin
      wrEnt = mkEntry(hitEnt_ff.mac, hitEnt_ff.port, hitEnt_ff.unknownLoc, 1'b1);
    end else if (isUpd) begin
      wrEnt = mkEntry(dstMac_ff, 1'b0, 1'b1, 1'b1);
    end
  end
  // decision for the destination phase
  wire logic dstKnown = hit_ff && !hitEnt_ff.unknownLoc;
  wire logic fwdNow = permDst[1] ? permDst[0] != arrPort_ff :
                      dstKnown ? hitEnt_ff.port != arrPort_ff : 1'b1;
  wire logic egress = permDst[1] ? permDst[0] : dstKnown ? hitEnt_ff.port : !arrPort_ff;
  wire logic endFrame = isUpd && (dstPhase_ff || learning_ff);

  // ****************************************
  // controller
  // ****************************************
  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lbf_pkg::ST_INIT: begin
        if (lastIssue) nxt_state = lbf_pkg::ST_IDLE;
      end
      lbf_pkg::ST_IDLE: begin
        if (ageDue_ff) nxt_state = lbf_pkg::ST_AGE;
        else if (frmValid) nxt_state = lbf_pkg::ST_SCAN;
      end
      lbf_pkg::ST_SCAN: begin
        if (scanDone) nxt_state = lbf_pkg::ST_UPDATE;
      end
      lbf_pkg::ST_UPDATE: begin
        nxt_state = endFrame ? lbf_pkg::ST_IDLE : lbf_pkg::ST_SCAN;
      end
      lbf_pkg::ST_AGE: begin
        if (scanDone) nxt_state = lbf_pkg::ST_IDLE;
      end
      default: nxt_state = lbf_pkg::ST_INIT;
    endcase
  end
  wire logic startScan = (state_ff == lbf_pkg::ST_IDLE && (ageDue_ff || frmValid)) ||
                         (isUpd && !endFrame);
  assign frmReady = state_ff == lbf_pkg::ST_IDLE && !ageDue_ff;
  // state, phase and latched frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= lbf_pkg::ST_INIT;
      dstPhase_ff <= 1'b0;
      srcMac_ff <= 48'h0000_0000_0000;
      dstMac_ff <= 48'h0000_0000_0000;
      arrPort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (frmValid && frmReady) begin
        srcMac_ff <= frmSrc;
        dstMac_ff <= frmDst;
        arrPort_ff <= frmPort;
        dstPhase_ff <= 1'b0;
      end else if (isUpd && !endFrame) begin
        dstPhase_ff <= 1'b1;
      end
    end
  end
  // scan address issue and read pipeline
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scanIdx_ff <= '0;
      issuing_ff <= 1'b1;
      rdValid_ff <= 1'b0;
      rdIdx_ff <= '0;
    end else begin
      rdValid_ff <= (isScan || isAge) && issuing_ff;
      rdIdx_ff <= scanIdx_ff;
      if (startScan) begin
        scanIdx_ff <= '0;
        issuing_ff <= 1'b1;
      end else if (issuing_ff && (isInit || isScan || isAge)) begin
        scanIdx_ff <= scanIdx_ff + 1'b1;
        issuing_ff <= !lastIssue;
      end
    end
  end
  // first match and first free slot of a scan
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hit_ff <= 1'b0;
      hitIdx_ff <= '0;
      hitEnt_ff <= '0;
      freeFound_ff <= 1'b0;
      freeIdx_ff <= '0;
    end else if (startScan) begin
      hit_ff <= 1'b0;
      freeFound_ff <= 1'b0;
    end else if (isScan) begin
      if (scanHit && !hit_ff) begin
        hit_ff <= 1'b1;
        hitIdx_ff <= rdIdx_ff;
        hitEnt_ff <= rdEnt;
      end
      if (scanFree && !freeFound_ff) begin
        freeFound_ff <= 1'b1;
        freeIdx_ff <= rdIdx_ff;
      end
    end
  end
  // decision output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      decValid_ff <= 1'b0;
      decForward_ff <= 1'b0;
      decPort_ff <= 1'b0;
    end else begin
      decValid_ff <= endFrame;
      decForward_ff <= endFrame && dstPhase_ff && fwdNow;
      decPort_ff <= dstPhase_ff ? egress : arrPort_ff;
    end
  end

  // ****************************************
  // timers, occupancy and alarm
  // ****************************************
  // listen-only period and aging interval run side by side, both after table clearing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      learning_ff <= 1'b1;
      learnCnt_ff <= `LBF_CNT_ONE;
      ageCnt_ff <= `LBF_CNT_ONE;
      ageDue_ff <= 1'b0;
    end else if (!isInit) begin
      if (learning_ff) begin
        learnCnt_ff <= learnCnt_ff + `LBF_CNT_ONE;
        if (learnTick) learning_ff <= 1'b0;
      end
      ageCnt_ff <= ageTick ? `LBF_CNT_ONE : ageCnt_ff + `LBF_CNT_ONE;
      ageDue_ff <= ageTick || (ageDue_ff && !(isAge && scanDone));
    end
  end
  // occupancy count and alarm with hysteresis
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 12'h0000;
      armed_ff <= 1'b1;
      fullAlarm_ff <= 1'b0;
    end else begin
      if (insertNow) count_ff <= count_ff + 12'h0001;
      else if (purge) count_ff <= count_ff - 12'h0001;
      fullAlarm_ff <= tableFull && armed_ff;
      if (tableFull && armed_ff) armed_ff <= 1'b0;
      else if (count_ff <= `LBF_REARM_CNT) armed_ff <= 1'b1;
    end
  end
  // permanent table, written only by management
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      permValid_ff <= '0;
      permMac_ff <= '0;
      permPort_ff <= '0;
    end else if (permWrEn) begin
      permValid_ff[permIdx] <= permValidIn;
      permMac_ff[permIdx] <= permMacIn;
      permPort_ff[permIdx] <= permPortIn;
    end
  end
  // aging table storage
  lbf_mem lbf_mem_inst (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrAddr(wrIdx),
    .wrData(wrEnt),
    .rdEn(isScan || isAge),
    .rdAddr(scanIdx_ff),
    .rdData_ff(rdData)
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence srcUpd;
    isUpd && !dstPhase_ff && !learning_ff;
  endsequence
  sequence dstScanStart;
    isScan && dstPhase_ff && scanIdx_ff == '0;
  endsequence
  AST_LEARN_NO_FWD: assert property (decValid_ff && $past(learning_ff) |-> !decForward_ff)
    else $error("frame forwarded while listening");
  AST_SRC_LEARN: assert property (isUpd && !dstPhase_ff && !permSrc[1] && !tableFull
                                  |-> wrEn && wrEnt.valid && wrEnt.port == arrPort_ff)
    else $error("source not recorded");
  AST_LEARN_END: assert property (learning_ff && !isInit && learnTick |=> !learning_ff)
    else $error("listen period did not end");
  AST_FWD_LEARN: assert property (isUpd && !dstPhase_ff && !learning_ff && !hit_ff && !permSrc[1]
                                  && !tableFull |-> insertNow)
    else $error("forwarding stopped learning");
  AST_SRC_FIRST: assert property (srcUpd |=> dstScanStart)
    else $error("destination looked up before source");
  AST_LOCAL_DROP: assert property (isUpd && dstPhase_ff && !permDst[1] && dstKnown
                                   && hitEnt_ff.port == arrPort_ff |=> decValid_ff && !decForward_ff)
    else $error("local frame not discarded");
  AST_UNKNOWN_FWD: assert property (isUpd && dstPhase_ff && !permDst[1] && !hit_ff
                                    |=> decValid_ff && decForward_ff && decPort_ff == !$past(arrPort_ff))
    else $error("unknown destination not forwarded");
  AST_LOC_FILL: assert property (isUpd && !dstPhase_ff && hit_ff && hitEnt_ff.unknownLoc && !permSrc[1]
                                 |-> wrEn && wrIdx == hitIdx_ff && !wrEnt.unknownLoc)
    else $error("unknown location not filled");
  AST_REMOTE_PORT: assert property (isUpd && dstPhase_ff && !permDst[1] && dstKnown
                                    && hitEnt_ff.port != arrPort_ff |=> decForward_ff
                                    && decPort_ff == $past(hitEnt_ff.port))
    else $error("wrong egress port");
  AST_FRESH_SET: assert property (updWr |-> wrEnt.fresh)
    else $error("fresh flag not set");
  AST_PURGE: assert property (purge |-> wrEn && !wrEnt.valid ##1 count_ff == $past(count_ff) - 12'h0001)
    else $error("stale entry not purged");
  AST_PERM_KEEP: assert property (isAge && !permWrEn |=> $stable({permValid_ff, permPort_ff, permMac_ff}))
    else $error("permanent entry changed by aging");
  AST_CAPACITY: assert property (count_ff <= `LBF_FULL_CNT)
    else $error("occupancy above capacity");
  AST_FULL_NOINS: assert property (tableFull |-> !insertNow)
    else $error("insert into full table");
  AST_ALARM_ONCE: assert property (fullAlarm_ff |-> !armed_ff ##1 !fullAlarm_ff)
    else $error("alarm repeated");
  AST_AGE_CLEAR: assert property (ageWr && rdEnt.fresh |-> wrEnt.valid && !wrEnt.fresh)
    else $error("fresh flag not cleared by aging");
endmodule : lbf_bridge
`default_nettype wire

// ### design/lbf_consts.svh
// constants of the learning bridge filter table
// Contract
// - no frame crosses segments during the initial listen-only period
// - every frame's source is recorded on its arrival segment
// - listen-only length comes from a setting; expiry enters forwarding
// - forwarding still learns new source addresses
// - source is looked up and added before the destination is evaluated
// - destination on the arrival segment means the frame is discarded
// - unmatched destination is forwarded and inserted with unknown location
// - source matching an unknown-location entry fills in the location
// - known remote destination leaves by the port stored in its entry
// - aging entry holds address, port identifier and one freshness flag
// - insertion or lookup match sets the entry's freshness flag
// - each aging expiry scans and deletes entries unused since last expiry
// - permanent entries sit in a separate table the aging scan skips
// - aging table holds exactly 2048 station entries
// - full table inserts nothing and forwards like an unknown destination
// - full alarm once; again only after dropping a third and refilling
`ifndef LBF_CONSTS_SVH
`define LBF_CONSTS_SVH
`define LBF_ADDR_W 11
`define LBF_ENTRY_W 52
`define LBF_LAST_IDX 11'h07FF
`define LBF_FULL_CNT 12'h0800
`define LBF_REARM_CNT 12'h0555
`define LBF_PERM_N 16
`define LBF_PERM_IW 4
`define LBF_CNT_ONE 32'h0000_0001
`endif

// ### design/lbf_mem.sv
// single write, single registered read memory for the aging table
`timescale 1ns/10ps
`default_nettype none
`include "lbf_consts.svh"
module lbf_mem (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // write side
  input wire logic wrEn,
  input wire logic [`LBF_ADDR_W-1:0] wrAddr,
  input wire logic [`LBF_ENTRY_W-1:0] wrData,
  // read side
  input wire logic rdEn,
  input wire logic [`LBF_ADDR_W-1:0] rdAddr,
  output logic [`LBF_ENTRY_W-1:0] rdData_ff
);
  logic [`LBF_ENTRY_W-1:0] mem [0:(1<<`LBF_ADDR_W)-1];

  // storage write, no reset on the array
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read, old data on a same-address write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else if (rdEn) begin
      rdData_ff <= mem[rdAddr];
    end
  end
endmodule : lbf_mem
`default_nettype wire

// ### design/lbf_pkg.sv
// types of the learning bridge filter table
`default_nettype none
`include "lbf_consts.svh"
package lbf_pkg;
  // controller states
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_SCAN, ST_UPDATE, ST_AGE
  } lbf_state_t;
  // one aging table entry
  typedef struct packed {
    logic valid;
    logic fresh;
    logic unknownLoc;
    logic port;
    logic [47:0] mac;
  } lbf_entry_t;
endpackage : lbf_pkg
`default_nettype wire

// ### testbench/lbf_bridge_tb_top.sv
// self-checking testbench of the learning bridge forwarding engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module lbf_bridge_tb_top;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clock, rst_n, frmValid, frmReady, frmPort, decValid_ff, decForward_ff, decPort_ff;
  logic [31:0] learnInterval, ageInterval;
  logic [47:0] frmSrc, frmDst, permMacIn;
  logic permWrEn, permValidIn, permPortIn, learning_ff, fullAlarm_ff, alarmSeen;
  logic [3:0] permIdx;
  logic [11:0] count_ff;
  int failures, n_compared;
  // station addresses used by the scenarios
  localparam logic [47:0] S1 = 48'h0200_0000_0001, S2 = 48'h0200_0000_0002, S3 = 48'h0200_0000_0003;
  localparam logic [47:0] S4 = 48'h0200_0000_0004, S5 = 48'h0200_0000_0005, PM = 48'h0200_0000_00F0;
  lbf_bridge lbf_bridge_inst (.clock(clock), .rst_n(rst_n), .learnInterval(learnInterval),
    .ageInterval(ageInterval), .frmValid(frmValid), .frmReady(frmReady), .frmSrc(frmSrc),
    .frmDst(frmDst), .frmPort(frmPort), .decValid_ff(decValid_ff), .decForward_ff(decForward_ff),
    .decPort_ff(decPort_ff), .permWrEn(permWrEn), .permIdx(permIdx), .permValidIn(permValidIn),
    .permMacIn(permMacIn), .permPortIn(permPortIn), .learning_ff(learning_ff), .count_ff(count_ff),
    .fullAlarm_ff(fullAlarm_ff));
  lbf_stations lbf_stations_inst (.clock(clock), .frmValid(frmValid), .frmReady(frmReady),
    .frmSrc(frmSrc), .frmDst(frmDst), .frmPort(frmPort));
  // clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // the table never fills here, so no alarm may ever appear
  always @(negedge clock) begin
    if (fullAlarm_ff === 1'b1) alarmSeen = 1'b1;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  // print counts and verdict, then stop
  task automatic conclude();
    $display("comparisons %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // send one frame, wait for its decision and check decision and occupancy
  task automatic frame(input logic [47:0] src, input logic [47:0] dst, input logic port, input logic fwd,
                       input logic egress, input logic [11:0] cnt);
    logic ok;
    int n;
    lbf_stations_inst.sendFrame(src, dst, port, ok);
    if (!ok) begin
      failures++;
      conclude();
    end
    ok = 1'b0;
    for (n = 0; n < 10000 && !ok; n++) begin
      if (decValid_ff === 1'b1) ok = 1'b1;
      else @(negedge clock);
    end
    if (!ok) begin
      failures++;
      conclude();
    end
    `CHK(decForward_ff, fwd)
    `CHK(decPort_ff, egress)
    repeat (2) @(negedge clock);
    `CHK(count_ff, cnt)
  endtask : frame
  // write one permanent slot with a one-cycle strobe
  task automatic permWrite(input logic [3:0] idx, input logic vld, input logic [47:0] mac, input logic prt);
    @(negedge clock);
    permWrEn = 1'b1;
    permIdx = idx;
    permValidIn = vld;
    permMacIn = mac;
    permPortIn = prt;
    @(negedge clock);
    permWrEn = 1'b0;
  endtask : permWrite
  // ****************************************
  // scenarios
  // ****************************************
  // listen-only: a frame is discarded but its source is learned, then forwarding starts
  task automatic listenOnly();
    int n;
    `CHK(learning_ff, 1'b1)
    frame(S1, S2, 1'b0, 1'b0, 1'b0, 12'h001);
    `CHK(learning_ff, 1'b1)
    for (n = 0; n < 20000 && learning_ff !== 1'b0; n++) @(negedge clock);
    `CHK(learning_ff, 1'b0)
  endtask : listenOnly
  // destination on the arrival segment is filtered, new source still learned
  task automatic localDiscard();
    frame(S2, S1, 1'b0, 1'b0, 1'b0, 12'h002);
  endtask : localDiscard
  // unknown destination crosses and is logged with unknown location
  task automatic unknownDst();
    frame(S1, S3, 1'b0, 1'b1, 1'b1, 12'h003);
  endtask : unknownDst
  // reply from the unknown station fills its entry, then it is reached by stored port
  task automatic locationFill();
    frame(S3, S2, 1'b1, 1'b1, 1'b0, 12'h003);
    frame(S2, S3, 1'b0, 1'b1, 1'b1, 12'h003);
    frame(S3, S1, 1'b1, 1'b1, 1'b0, 12'h003);
  endtask : locationFill
  // permanent entry steers the frame and takes no aging slot
  task automatic permanentHit();
    permWrite(4'h3, 1'b1, PM, 1'b1);
    frame(S1, PM, 1'b0, 1'b1, 1'b1, 12'h003);
  endtask : permanentHit
  // idle table is aged to empty, permanent entry survives
  task automatic agingPurge();
    int n;
    @(negedge clock);
    ageInterval = 32'h0000_09C4;
    for (n = 0; n < 30000 && count_ff !== 12'h000; n++) @(negedge clock);
    `CHK(count_ff, 12'h000)
    ageInterval = 32'hFFFF_FFFF;
    frame(S4, PM, 1'b0, 1'b1, 1'b1, 12'h001);
    frame(S5, S4, 1'b1, 1'b1, 1'b0, 12'h002);
  endtask : agingPurge
  // removed permanent entry makes the address unknown again
  task automatic permanentRemove();
    permWrite(4'h3, 1'b0, PM, 1'b1);
    frame(S4, PM, 1'b0, 1'b1, 1'b1, 12'h003);
  endtask : permanentRemove
  // reset in mid-run empties the aging table and returns to listen-only
  task automatic midReset();
    @(negedge clock);
    rst_n = 1'b0;
    @(negedge clock);
    `CHK(count_ff, 12'h000)
    `CHK(learning_ff, 1'b1)
    `CHK(frmReady, 1'b0)
    rst_n = 1'b1;
    frame(S5, S4, 1'b1, 1'b0, 1'b1, 12'h001);
  endtask : midReset
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    failures = 0;
    n_compared = 0;
    alarmSeen = 1'b0;
    rst_n = 1'b0;
    learnInterval = 32'h0000_0FA0;
    ageInterval = 32'hFFFF_FFFF;
    permWrEn = 1'b0;
    permIdx = 4'h0;
    permValidIn = 1'b0;
    permMacIn = 48'h0000_0000_0000;
    permPortIn = 1'b0;
    repeat (16) @(negedge clock);
    `CHK(frmReady, 1'b0)
    `CHK(count_ff, 12'h000)
    rst_n = 1'b1;
    listenOnly();
    localDiscard();
    unknownDst();
    locationFill();
    permanentHit();
    agingPurge();
    permanentRemove();
    midReset();
    `CHK(alarmSeen, 1'b0)
    conclude();
  end
endmodule : lbf_bridge_tb_top
`default_nettype wire

// ### testbench/lbf_stations.sv
// station model for both lan segments: offers frame headers to the bridge
`timescale 1ns/10ps
`default_nettype none
module lbf_stations (
  // clock
  input wire logic clock,
  // frame header offer
  output logic frmValid,
  input wire logic frmReady,
  output logic [47:0] frmSrc,
  output logic [47:0] frmDst,
  output logic frmPort
);
  // ****************************************
  // header offer
  // ****************************************
  // idle fields carry a pattern so stale data can never pass for a header
  initial begin
    frmValid = 1'b0;
    frmSrc = 48'h5555_5555_5555;
    frmDst = 48'hAAAA_AAAA_AAAA;
    frmPort = 1'b0;
  end
  // offer one header, hold it until the edge that takes it, then scramble the lines
  task automatic sendFrame(input logic [47:0] src, input logic [47:0] dst, input logic port, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge clock);
    frmValid = 1'b1;
    frmSrc = src;
    frmDst = dst;
    frmPort = port;
    // ready seen at a falling edge means the next rising edge takes the header
    for (n = 0; n < 20000 && !ok; n++) begin
      if (frmReady === 1'b1) ok = 1'b1;
      @(negedge clock);
    end
    frmValid = 1'b0;
    frmSrc = ~src;
    frmDst = ~dst;
    frmPort = ~port;
  endtask : sendFrame
endmodule : lbf_stations
`default_nettype wire
